// >>> rtl/sdh_pkg.sv
// package: opcodes, register map and timing constants of the sdram host controller
package sdh_pkg;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_MRS,
    OP_ZQCL,
    OP_ZQCS,
    OP_ACT,
    OP_RD,
    OP_RDA,
    OP_WR,
    OP_PRE,
    OP_PREA
  } sdh_op_e;

  localparam logic [7:0] REG_CMD  = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_RDLO = 8'h08;
  localparam logic [7:0] REG_RDHI = 8'h0c;
  localparam logic [7:0] REG_CTRL = 8'h10;

  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_BANK_LSB = 4;
  localparam int CMD_BC4_BIT  = 7;
  localparam int CMD_ADDR_LSB = 16;

  localparam int ST_BUSY     = 0;
  localparam int ST_RDDONE   = 1;
  localparam int ST_DQSERR   = 2;
  localparam int ST_ZQ       = 3;
  localparam int ST_BURST    = 4;
  localparam int ST_OPEN_LSB = 8;

  localparam int   CTRL_CKE     = 0;
  localparam logic CTRL_CKE_RST = 1'b0;

  localparam int PCLK_NS = 100;
  localparam int T_CK_NS = 2 * PCLK_NS;

  // time to clock count: round up, never below min_ck
  function automatic int ns2ck(int ns, int min_ck);
    int c;
    c = (ns + T_CK_NS - 1) / T_CK_NS;
    return (c < min_ck) ? min_ck : c;
  endfunction

  localparam int T_RP_NS  = 15;
  localparam int T_RCD_NS = 15;
  localparam int T_RAS_NS = 35;
  localparam int T_RC_NS  = 50;
  localparam int T_RRD_NS = 10;
  localparam int T_FAW_NS = 40;
  localparam int T_RTP_NS = 10;

  localparam int T_MRD_CK    = 4;
  localparam int T_MOD_CK    = 12;
  localparam int T_CCD_CK    = 4;
  localparam int T_ZQINIT_CK = 512;
  localparam int T_ZQOPER_CK = 256;
  localparam int T_ZQCS_CK   = 64;
  localparam int RD_PRE_CK   = 4;

  localparam int T_RP_CK  = ns2ck(T_RP_NS, 1);
  localparam int T_RCD_CK = ns2ck(T_RCD_NS, 1);
  localparam int T_RAS_CK = ns2ck(T_RAS_NS, 1);
  localparam int T_RC_CK  = ns2ck(T_RC_NS, 1);
  localparam int T_RRD_CK = ns2ck(T_RRD_NS, 4);
  localparam int T_FAW_CK = ns2ck(T_FAW_NS, 1);
  localparam int T_RTP_CK = ns2ck(T_RTP_NS, 4);

  localparam int BURST_LEN = 8;
  localparam int CHOP_LEN  = 4;
  localparam int CW        = 10;

endpackage

// >>> rtl/sdh_cnt.sv
// loadable down counter that times one command spacing in link clocks
`timescale 1ns/1ps
module sdh_cnt #(
  parameter int W = 10
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         tick,
  input  wire logic         ld,
  input  wire logic [W-1:0] val,
  output logic      [W-1:0] cnt,
  output logic              zero
);

  generate
    if (W < 2) begin : g_bad
      $error("sdh_cnt: width too small");
    end
  endgenerate

  // a load wins over a tick so a fresh spacing is never shortened
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (ld) begin
      cnt <= val;
    end else if (tick && cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign zero = (cnt == '0);

endmodule

// >>> rtl/sdh_ctrl.sv
// sdram host controller: apb command registers, bank timing, read capture
// Notes on behaviour
// RQ1: mode register index in low bank bits
// RQ2: mode set only when idle and precharged
// RQ3: wait mode-set delays before later commands
// RQ4: calibrate only with all banks precharged
// RQ5: only calibration commands during calibration interval
// RQ6: long and short calibration, different durations
// RQ7: explicit long calibration after self refresh
// RQ8: ranks sharing resistor never calibrate together
// RQ9: calibration: clock enable high, termination off
// RQ10: read or write needs open row, tRCD
// RQ11: times round up to whole clocks
// RQ12: reads and writes spaced by tCCD
// RQ13: reactivate bank after precharge, tRC apart
// RQ14: tRRD between activates, four per tFAW
// RQ15: address bit ten selects auto precharge
// RQ16: first read element RL clocks later
// RQ17: strobe preamble low, then high impedance
// RQ18: spaced reads chain without gap, no truncation
// RQ19: read-to-write spacing RL+tCCD-WL+2 clocks
// RQ20: read-to-precharge four clocks and tRTP
// RQ21: auto precharge after AL+tRTP, tRAS lockout
// RQ22: same bank waits tRP after precharge
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module sdh_ctrl
  import sdh_pkg::*;
#(
  parameter int AL      = 0,
  parameter int CL      = 5,
  parameter int CWL     = 5,
  parameter int DQ_W    = 8,
  parameter int CAP_ADJ = 3
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  output logic                 ck,
  output logic                 ck_n,
  output logic                 cke,
  output logic                 cs_n,
  output logic                 ras_n,
  output logic                 cas_n,
  output logic                 we_n,
  output logic      [2:0]      ba,
  output logic      [13:0]     a,
  output logic                 odt,
  input  wire logic [DQ_W-1:0] dq_i,
  output logic      [DQ_W-1:0] dq_o,
  output logic                 dq_oe,
  input  wire logic            dqs_i,
  output logic                 dqs_o,
  output logic                 dqs_oe
);

  localparam int RL  = AL + CL;
  localparam int WL  = AL + CWL;
  localparam int CAP = 2 * RL + CAP_ADJ;
  localparam int PL  = CAP + BURST_LEN + 1;
  localparam int G_MRD = 0;
  localparam int G_MOD = 1;
  localparam int G_ZQ  = 2;
  localparam int G_RRD = 3;
  localparam int G_CCD = 4;
  localparam int G_R2W = 5;
  localparam int G_FAW = 6;
  localparam int B0    = 10;
  localparam int BK    = 5;
  localparam int K_RCD = 0;
  localparam int K_RC  = 1;
  localparam int K_RAS = 2;
  localparam int K_RTP = 3;
  localparam int K_RP  = 4;
  localparam int NT    = B0 + 8 * BK;

  generate
    if (DQ_W != 8 || CL < 1 || AL < 0 || AL >= CL || CAP_ADJ < 1) begin : g_bad
      $error("sdh_ctrl: unsupported latency or width");
    end
  endgenerate

  function automatic logic [CW-1:0] ldv(int n);
    return (n > 1) ? CW'(n - 1) : '0;
  endfunction

  logic            ck_en;
  logic            pend;
  sdh_op_e         pend_op;
  logic [2:0]      pend_bank;
  logic            pend_bc4;
  logic [13:0]     pend_addr;
  logic            iss;
  logic            ok;
  logic [7:0]      open;
  logic            zq_first;
  logic [NT-1:0]   ld;
  logic [CW-1:0]   val  [NT];
  logic [CW-1:0]   cnt  [NT];
  logic [NT-1:0]   zero;
  logic            rp_all;
  logic            ras_all;
  logic            faw_free;
  int              faw_slot;
  logic [PL-1:0]   rd_pipe;
  logic [PL-1:0]   last_pipe;
  logic [DQ_W-1:0] dq_m;
  logic [DQ_W-1:0] dq_s;
  logic            dqs_m;
  logic            dqs_s;
  logic [2:0]      ecnt;
  logic [63:0]     rbuf;
  logic [63:0]     next_rbuf;
  logic [63:0]     rdata;
  logic            rd_done;
  logic            dqs_err;
  logic [31:0]     rd_mux;
  logic            map_ok;
  logic [13:0]     next_a;
  logic [3:0]      pin_cmd;

  wire apb_set = psel && !penable;
  wire apb_wr  = psel && penable && pready && pwrite && !pslverr;
  wire zq_busy = !zero[G_ZQ];
  wire burst   = |rd_pipe;
  wire is_rd   = iss && (pend_op == OP_RD || pend_op == OP_RDA);

  // link clock is pclk divided by two; commands change as ck falls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck   <= 1'b0;
      ck_n <= 1'b1;
    end else begin
      ck   <= !ck;
      ck_n <= ck;
    end
  end

  assign ck_en = ck;

  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_tmr
      sdh_cnt #(.W(CW)) u_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (ck_en),
        .ld      (ld[gi]),
        .val     (val[gi]),
        .cnt     (cnt[gi]),
        .zero    (zero[gi])
      );
    end
  endgenerate

  always_comb begin
    rp_all   = 1'b1;
    ras_all  = 1'b1;
    faw_free = 1'b0;
    faw_slot = 0;
    for (int b = 0; b < 8; b++) begin
      rp_all  = rp_all && zero[B0 + b * BK + K_RP] && zero[B0 + b * BK + K_RTP];
      ras_all = ras_all && zero[B0 + b * BK + K_RAS];
    end
    for (int f = 3; f >= 0; f--) begin
      if (zero[G_FAW + f]) begin
        faw_free = 1'b1;
        faw_slot = f;
      end
    end
  end

  // issue check: every spacing is a counter that must have run out
  always_comb begin
    int bi;
    bi = B0 + int'(pend_bank) * BK;
    ok = 1'b0;
    case (pend_op)
      OP_MRS: ok = (open == '0) && rp_all && !burst && !zq_busy && zero[G_MRD]; // [RQ2]
      OP_ZQCL, OP_ZQCS: ok = (open == '0) && rp_all && !burst && zero[G_MRD]; // [RQ4]
      OP_ACT: ok = !zq_busy && zero[G_MRD] && !open[pend_bank] // [RQ5] [RQ13]
                   && zero[bi + K_RP] && zero[bi + K_RC] // [RQ22]
                   && zero[G_RRD] && faw_free; // [RQ14]
      OP_RD, OP_RDA: ok = !zq_busy && zero[G_MOD] && open[pend_bank] // [RQ3]
                          && zero[bi + K_RCD] && zero[G_CCD]; // [RQ10] [RQ12] [RQ18]
      OP_WR: ok = !zq_busy && zero[G_MOD] && open[pend_bank] && zero[bi + K_RCD]
                  && zero[G_CCD] && zero[G_R2W]; // [RQ19]
      OP_PRE: ok = !zq_busy && zero[G_MRD] && zero[bi + K_RAS] && zero[bi + K_RTP]; // [RQ20]
      OP_PREA: ok = !zq_busy && zero[G_MRD] && ras_all && rp_all;
      default: ok = 1'b1;
    endcase
  end

  // nothing but nop leaves while clock enable is low
  assign iss = ck_en && pend && ok && (cke || pend_op == OP_NOP);

  always_comb begin
    int bi;
    int ap;
    bi = B0 + int'(pend_bank) * BK;
    ap = 0;
    ld = '0;
    for (int i = 0; i < NT; i++) begin
      val[i] = '0;
    end
    if (iss) begin
      case (pend_op)
        OP_MRS: begin
          ld[G_MRD]  = 1'b1;
          val[G_MRD] = ldv(T_MRD_CK); // [RQ3]
          ld[G_MOD]  = 1'b1;
          val[G_MOD] = ldv(T_MOD_CK);
        end
        OP_ZQCL, OP_ZQCS: begin
          if (pend_op == OP_ZQCS) begin
            val[G_ZQ] = ldv(T_ZQCS_CK); // [RQ6]
          end else begin
            val[G_ZQ] = zq_first ? ldv(T_ZQINIT_CK) : ldv(T_ZQOPER_CK);
          end
          // single rank, so windows cannot overlap; a short one never cuts a long one
          ld[G_ZQ] = (val[G_ZQ] >= cnt[G_ZQ]); // [RQ5] [RQ8]
        end
        OP_ACT: begin
          ld[G_RRD]             = 1'b1;
          val[G_RRD]            = ldv(T_RRD_CK); // [RQ14]
          ld[G_FAW + faw_slot]  = 1'b1;
          val[G_FAW + faw_slot] = ldv(T_FAW_CK);
          ld[bi + K_RCD]        = 1'b1;
          val[bi + K_RCD]       = ldv(T_RCD_CK - AL); // [RQ10] [RQ11]
          ld[bi + K_RC]         = 1'b1;
          val[bi + K_RC]        = ldv(T_RC_CK); // [RQ13]
          ld[bi + K_RAS]        = 1'b1;
          val[bi + K_RAS]       = ldv(T_RAS_CK);
        end
        OP_RD, OP_RDA: begin
          ld[G_CCD]  = 1'b1;
          val[G_CCD] = ldv(T_CCD_CK); // [RQ12]
          ld[G_R2W]  = 1'b1;
          val[G_R2W] = ldv(RL + T_CCD_CK - WL + 2); // [RQ19]
          if (pend_op == OP_RD) begin
            ld[bi + K_RTP]  = 1'b1;
            val[bi + K_RTP] = ldv((AL + T_RTP_CK > RD_PRE_CK) ? AL + T_RTP_CK : RD_PRE_CK);
          end else begin
            // model the internal precharge point, then tRP from it
            ap = (AL + T_RTP_CK > RD_PRE_CK) ? AL + T_RTP_CK : RD_PRE_CK; // [RQ21]
            if (int'(cnt[bi + K_RAS]) + 1 > ap) begin
              ap = int'(cnt[bi + K_RAS]) + 1;
            end
            ld[bi + K_RP]  = 1'b1;
            val[bi + K_RP] = ldv(ap + T_RP_CK); // [RQ22]
          end
        end
        OP_WR: begin
          ld[G_CCD]  = 1'b1;
          val[G_CCD] = ldv(T_CCD_CK);
        end
        OP_PRE: begin
          ld[bi + K_RP]  = 1'b1;
          val[bi + K_RP] = ldv(T_RP_CK); // [RQ22]
        end
        OP_PREA: begin
          for (int b = 0; b < 8; b++) begin
            ld[B0 + b * BK + K_RP]  = 1'b1;
            val[B0 + b * BK + K_RP] = ldv(T_RP_CK);
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open     <= '0;
      zq_first <= 1'b1;
    end else if (iss) begin
      case (pend_op)
        OP_ACT:  open[pend_bank] <= 1'b1;
        OP_PRE:  open[pend_bank] <= 1'b0;
        OP_RDA:  open[pend_bank] <= 1'b0; // [RQ15]
        OP_PREA: open <= '0;
        OP_ZQCL: zq_first <= 1'b0; // [RQ7]
        default: ;
      endcase
    end
  end

  always_comb begin
    next_a  = pend_addr;
    pin_cmd = 4'b0111;
    case (pend_op)
      OP_MRS:  pin_cmd = 4'b0000;
      OP_ZQCL: begin
        pin_cmd    = 4'b0110;
        next_a[10] = 1'b1;
      end
      OP_ZQCS: begin
        pin_cmd    = 4'b0110;
        next_a[10] = 1'b0;
      end
      OP_ACT:  pin_cmd = 4'b0011;
      OP_RD, OP_RDA, OP_WR: begin
        pin_cmd    = (pend_op == OP_WR) ? 4'b0100 : 4'b0101;
        next_a[10] = (pend_op == OP_RDA); // [RQ15]
        next_a[12] = !pend_bc4;
      end
      OP_PRE, OP_PREA: begin
        pin_cmd    = 4'b0010;
        next_a[10] = (pend_op == OP_PREA);
      end
      default: pin_cmd = 4'b0111;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cs_n, ras_n, cas_n, we_n} <= 4'b1111;
      ba <= '0;
      a  <= '0;
    end else if (ck_en) begin
      {cs_n, ras_n, cas_n, we_n} <= iss ? pin_cmd : 4'b0111;
      if (iss) begin
        ba <= (pend_op == OP_MRS) ? {1'b0, pend_bank[1:0]} : pend_bank; // [RQ1]
        a  <= next_a;
      end
    end
  end

  // the host never drives the data bus or termination: reads only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odt    <= 1'b0;
      dq_o   <= '0;
      dq_oe  <= 1'b0;
      dqs_o  <= 1'b0;
      dqs_oe <= 1'b0;
    end else begin
      odt    <= 1'b0; // [RQ9]
      dq_oe  <= 1'b0;
      dqs_oe <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend      <= 1'b0;
      pend_op   <= OP_NOP;
      pend_bank <= '0;
      pend_bc4  <= 1'b0;
      pend_addr <= '0;
    end else if (apb_wr && paddr == REG_CMD) begin
      pend      <= 1'b1;
      pend_op   <= sdh_op_e'(pwdata[CMD_OP_LSB +: 4]);
      pend_bank <= pwdata[CMD_BANK_LSB +: 3];
      pend_bc4  <= pwdata[CMD_BC4_BIT];
      pend_addr <= pwdata[CMD_ADDR_LSB +: 14];
    end else if (iss) begin
      pend <= 1'b0;
    end
  end

  // clock enable holds its value while calibration runs or a command waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cke <= CTRL_CKE_RST;
    end else if (apb_wr && paddr == REG_CTRL && !zq_busy && !pend) begin
      cke <= pwdata[CTRL_CKE]; // [RQ9]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_m  <= '0;
      dq_s  <= '0;
      dqs_m <= 1'b0;
      dqs_s <= 1'b0;
    end else begin
      dq_m  <= dq_i;
      dq_s  <= dq_m;
      dqs_m <= dqs_i;
      dqs_s <= dqs_m;
    end
  end

  // one pipe bit per half clock marks where a burst element is due
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_pipe   <= '0;
      last_pipe <= '0;
    end else if (is_rd) begin
      rd_pipe   <= (rd_pipe >> 1) | ((pend_bc4 ? PL'(8'h0f) : PL'(8'hff)) << CAP); // [RQ16]
      last_pipe <= (last_pipe >> 1) | (PL'(1) << (CAP + (pend_bc4 ? CHOP_LEN : BURST_LEN) - 1));
    end else begin
      rd_pipe   <= rd_pipe >> 1;
      last_pipe <= last_pipe >> 1;
    end
  end

  always_comb begin
    next_rbuf = (ecnt == 3'h0) ? 64'h0 : rbuf;
    next_rbuf[int'(ecnt) * 8 +: 8] = dq_s;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecnt  <= '0;
      rbuf  <= '0;
      rdata <= '0;
    end else if (rd_pipe[0]) begin
      rbuf <= next_rbuf;
      ecnt <= last_pipe[0] ? 3'h0 : ecnt + 3'h1; // [RQ18]
      if (last_pipe[0]) begin
        rdata <= next_rbuf;
      end
    end
  end

  // a new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_done <= 1'b0;
      dqs_err <= 1'b0;
    end else begin
      rd_done <= (rd_pipe[0] && last_pipe[0])
                 || (rd_done && !(apb_wr && paddr == REG_STAT && pwdata[ST_RDDONE]));
      dqs_err <= (rd_pipe[1] && !rd_pipe[0] && dqs_s) // [RQ17]
                 || (dqs_err && !(apb_wr && paddr == REG_STAT && pwdata[ST_DQSERR]));
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    map_ok = 1'b1;
    case (paddr)
      REG_CMD: begin
        rd_mux[CMD_OP_LSB +: 4]    = pend_op;
        rd_mux[CMD_BANK_LSB +: 3]  = pend_bank;
        rd_mux[CMD_BC4_BIT]        = pend_bc4;
        rd_mux[CMD_ADDR_LSB +: 14] = pend_addr;
      end
      REG_STAT: begin
        rd_mux[ST_BUSY]           = pend;
        rd_mux[ST_RDDONE]         = rd_done;
        rd_mux[ST_DQSERR]         = dqs_err;
        rd_mux[ST_ZQ]             = zq_busy;
        rd_mux[ST_BURST]          = burst;
        rd_mux[ST_OPEN_LSB +: 8]  = open;
      end
      REG_RDLO: rd_mux = rdata[31:0];
      REG_RDHI: rd_mux = rdata[63:32];
      REG_CTRL: rd_mux[CTRL_CKE] = cke;
      default:  map_ok = 1'b0;
    endcase
  end

  // zero-wait slave: answer registered during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= apb_set;
      pslverr <= apb_set && (!map_ok || (pwrite && paddr == REG_CMD && pend));
      prdata  <= (apb_set && !pwrite) ? rd_mux : 32'h0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire is_mrs = iss && pend_op == OP_MRS;
  wire is_zq  = iss && (pend_op == OP_ZQCL || pend_op == OP_ZQCS);
  wire is_act = iss && pend_op == OP_ACT;
  wire is_cmd = iss && pend_op != OP_NOP;

  sequence s_mrs;
    is_mrs;
  endsequence

  sequence s_zq;
    is_zq;
  endsequence

  property p_mrs_idle;
    s_mrs |-> (open == '0) && !burst;
  endproperty
  a_mrs_idle: assert property (p_mrs_idle) else $error("mode set while busy"); // [RQ2]

  property p_mrs_pins;
    s_mrs |=> ({cs_n, ras_n, cas_n, we_n} == 4'b0000) && !ba[2];
  endproperty
  a_mrs_pins: assert property (p_mrs_pins) else $error("bad mode set pins"); // [RQ1]

  property p_mrd_wait;
    s_mrs |=> !is_cmd [*7];
  endproperty
  a_mrd_wait: assert property (p_mrd_wait) else $error("command inside tMRD"); // [RQ3]

  property p_zq_prech;
    s_zq |-> (open == '0) && rp_all;
  endproperty
  a_zq_prech: assert property (p_zq_prech) else $error("calibration with bank open"); // [RQ4]

  property p_zq_quiet;
    s_zq |=> (!is_cmd || is_zq) [*8];
  endproperty
  a_zq_quiet: assert property (p_zq_quiet) else $error("traffic during calibration"); // [RQ5]

  property p_zq_pins;
    zq_busy |-> cke && !odt && !dq_oe && !dqs_oe;
  endproperty
  a_zq_pins: assert property (p_zq_pins) else $error("pins wrong in calibration"); // [RQ9]

  property p_rd_open;
    is_rd |-> open[pend_bank] ##1 !is_rd [*7];
  endproperty
  a_rd_open: assert property (p_rd_open) else $error("read spacing or row"); // [RQ10] [RQ12]

  property p_act_bank;
    is_act |-> !open[pend_bank] ##1 open[$past(pend_bank)];
  endproperty
  a_act_bank: assert property (p_act_bank) else $error("activate on open bank"); // [RQ13]

  property p_rd_data;
    is_rd |-> ##(CAP + 1) rd_pipe[0];
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read window misplaced"); // [RQ16]

endmodule

// >>> verif/sdh_mem_model.sv
// behavioural sdram device: decodes commands, keeps mode registers, returns read bursts
`timescale 1ns/1ps
module sdh_mem_model
  import sdh_pkg::*;
#(
  parameter int RL = 5
) (
  input  wire logic        ck,
  input  wire logic        presetn,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [13:0] a,
  input  wire logic        bad_pre,
  output logic      [7:0]  dq,
  output logic             dqs
);
  logic [13:0] mr [4];
  logic [7:0]  open_m;
  logic [2:0]  c;
  logic        zq_first;
  int          viol;
  int          zq_left;
  int          zlen;
  int          hc;
  int          nb;
  int          cur;
  int          idx;
  int          len;
  int          q_t[$];
  int          q_n[$];
  int          q_l[$];

  assign c = {ras_n, cas_n, we_n};

  // both ck edges carry data, so one process keeps the half-clock count
  always @(posedge ck or negedge ck or negedge presetn) begin
    if (!presetn) begin
      open_m   = 8'h00;
      viol     = 0;
      zq_left  = 0;
      zq_first = 1'b1;
      nb       = 0;
      hc       = 0;
      len      = 0;
      dq       = 8'h00;
      dqs      = 1'b1;
      q_t.delete();
      q_n.delete();
      q_l.delete();
    end else begin
      hc = hc + 1;
      if (q_t.size() > 0 && q_t[0] == hc) begin
        void'(q_t.pop_front());
        cur = q_n.pop_front();
        len = q_l.pop_front();
        idx = 0;
      end else if (len > 0) begin
        idx = idx + 1;
      end
      if (len > 0 && idx < len) begin
        dq  = 8'(cur * 16 + idx);
        dqs = ~idx[0];
      end else begin
        len = 0;
        // released bus never holds its last value
        dq  = ~dq;
        dqs = (q_t.size() > 0 && q_t[0] == hc + 1) ? bad_pre : 1'b1;
      end
      if (ck && zq_left > 0) zq_left--;
      if (ck && !cs_n && c != 3'b111) begin
        if (zq_left > 0 && c != 3'b110) viol++;
        case (c)
          3'b000: begin
            if (!ba[2]) mr[ba[1:0]] = a;
            if (open_m != 8'h00) viol++;
          end
          3'b011: begin
            if (open_m[ba]) viol++;
            open_m[ba] = 1'b1;
          end
          3'b101: begin
            if (!open_m[ba]) viol++;
            q_t.push_back(hc + 2 * RL);
            q_n.push_back(nb);
            q_l.push_back(a[12] ? BURST_LEN : CHOP_LEN);
            nb++;
            if (a[10]) open_m[ba] = 1'b0;
          end
          3'b010: begin
            if (a[10]) open_m = 8'h00;
            else open_m[ba] = 1'b0;
          end
          3'b110: begin
            if (open_m != 8'h00) viol++;
            zlen = !a[10] ? T_ZQCS_CK : zq_first ? T_ZQINIT_CK : T_ZQOPER_CK;
            if (zlen > zq_left) zq_left = zlen;
            if (a[10]) zq_first = 1'b0;
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// >>> verif/test_sdh_ctrl.sv
// self-checking bench: apb command sequences against the behavioural sdram model
`timescale 1ns/1ps
module test_sdh_ctrl
  import sdh_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ck;
  logic        ck_n;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [2:0]  ba;
  logic [13:0] a;
  logic        odt;
  logic [7:0]  dq_i;
  logic        dqs_i;
  logic [7:0]  dq_o;
  logic        dq_oe;
  logic        dqs_o;
  logic        dqs_oe;
  logic        bad_pre;
  logic [31:0] rd;
  logic        err;
  int          errors;
  int          num_checks;
  int          cyc;

  sdh_ctrl i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ck(ck), .ck_n(ck_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .a(a), .odt(odt), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
    .dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_oe(dqs_oe)
  );

  sdh_mem_model #(.RL(5)) i_mem (
    .ck(ck), .presetn(presetn), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .a(a), .bad_pre(bad_pre), .dq(dq_i), .dqs(dqs_i)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdw(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wait_clr(input logic [31:0] m);
    rd = m;
    while ((rd & m) !== 32'h0) apb(1'b0, REG_STAT, 32'h0);
  endtask

  function automatic logic [31:0] cw(input sdh_op_e op, input int bk, input logic [13:0] ad,
                                     input logic bc);
    return {2'h0, ad, 8'h00, bc, 3'(bk), op};
  endfunction

  task automatic cmd(input sdh_op_e op, input int bk, input logic [13:0] ad, input logic bc);
    apb(1'b1, REG_CMD, cw(op, bk, ad, bc));
    wait_clr(32'h1);
  endtask

  // element k of burst n carries n*16+k, four elements to a word
  function automatic logic [31:0] word(input int n, input int k);
    for (int i = 0; i < 4; i++) word[8*i +: 8] = 8'(n * 16 + k + i);
  endfunction

  task automatic rd_done(input logic [31:0] lo, input logic [31:0] hi);
    wait_clr(32'h10);
    // capture lands three pclk after the last element
    repeat (4) @(posedge pclk);
    rdw(REG_RDLO, lo);
    rdw(REG_RDHI, hi);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_pre = 1'b0;
    errors = 0;
    num_checks = 0;
    cyc = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({15'h0, dq_o, dq_oe, dqs_o, dqs_oe, cke, odt, cs_n, ras_n, ck, ck_n}, 32'h6);
    rdw(REG_STAT, 32'h0);
    rdw(REG_CTRL, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("test reset and map done");
    apb(1'b1, REG_CTRL, 32'h1);
    for (int b = 0; b < 4; b++) begin
      cmd(OP_MRS, b, 14'(16'h0a50 + b), 1'b0);
      repeat (2) @(posedge pclk);
      chk({18'h0, i_mem.mr[b]}, 32'(16'h0a50 + b));
    end
    $display("test mode set done");
    cmd(OP_ZQCL, 0, 14'h0400, 1'b0);
    apb(1'b0, REG_STAT, 32'h0);
    chk(rd & 32'h8, 32'h8);
    chk({30'h0, cke, odt}, 32'h2);
    cmd(OP_ZQCS, 0, 14'h0, 1'b0);
    apb(1'b1, REG_CMD, cw(OP_ACT, 2, 14'h0055, 1'b0));
    apb(1'b1, REG_CMD, cw(OP_NOP, 0, 14'h0, 1'b0));
    chk({31'h0, err}, 32'h1);
    wait_clr(32'h1);
    apb(1'b0, REG_STAT, 32'h0);
    chk(rd & 32'hff08, 32'h0400);
    $display("test calibration done");
    cmd(OP_RD, 2, 14'h0, 1'b0);
    cmd(OP_RD, 2, 14'h0008, 1'b0);
    rd_done(word(1, 0), word(1, 4));
    cmd(OP_RD, 2, 14'h0, 1'b1);
    rd_done(word(2, 0), 32'h0);
    bad_pre <= 1'b1;
    cmd(OP_RD, 2, 14'h0, 1'b0);
    rd_done(word(3, 0), word(3, 4));
    bad_pre <= 1'b0;
    rdw(REG_STAT, 32'h0406);
    apb(1'b1, REG_STAT, 32'h6);
    rdw(REG_STAT, 32'h0400);
    $display("test read bursts done");
    cmd(OP_RDA, 2, 14'h0400, 1'b0);
    rd_done(word(4, 0), word(4, 4));
    rdw(REG_STAT, 32'h2);
    cmd(OP_ACT, 2, 14'h0077, 1'b0);
    cmd(OP_PRE, 2, 14'h0, 1'b0);
    rdw(REG_STAT, 32'h2);
    cmd(OP_ACT, 2, 14'h0077, 1'b0);
    cmd(OP_PREA, 0, 14'h0400, 1'b0);
    repeat (4) @(posedge pclk);
    rdw(REG_STAT, 32'h2);
    chk(32'(i_mem.viol), 32'h0);
    $display("test precharge done");
    end_of_test();
  end
endmodule
